// ===== rtl/tpwm_top.sv
// Three-phase center-based modulator with dead time, crossover, chopping and shutdown.
`timescale 1ns/1ns
`include "tpwm_consts.svh"
module tpwm_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Avalon-MM slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Shutdown sources from outside the clock domain.
   input wire logic trip_input_n,
   input wire logic analog_shutdown,
   // Gate drive outputs.
   output logic phase_a_high,
   output logic phase_a_low,
   output logic phase_b_high,
   output logic phase_b_low,
   output logic phase_c_high,
   output logic phase_c_low,
   // Sync and interrupts to the core.
   output logic period_sync_pulse,
   output logic sync_irq,
   output logic shutdown_irq
);
   // Software copies of the registers.
   tpwm_pkg::tpwm_word_t half_period_count_reg; // Half-period length in cycles.
   logic [9:0] dead_time_reg; // Dead time in units of two cycles.
   logic [9:0] pulse_deletion_reg; // Narrowest pulse kept.
   tpwm_pkg::tpwm_word_t duty_reg [3]; // Phase A, B and C duties.
   logic [8:0] output_segment_reg; // Enables and crossover bits.
   logic [9:0] gate_chop_ctrl_reg; // Chop frequency and group enables.
   logic [15:0] mode_control_reg; // Holds the update mode bit.
   logic [7:0] sync_width_reg; // Sync width minus one.
   // Values latched into the timing unit at each update point.
   tpwm_pkg::tpwm_word_t tm_l;
   logic [9:0] dt_l;
   logic [9:0] pd_l;
   tpwm_pkg::tpwm_word_t duty_l [3];
   logic [8:0] seg_l;
   logic [7:0] syncw_l;
   // Timing unit state.
   tpwm_pkg::tpwm_word_t cnt_r;
   tpwm_pkg::tpwm_half_t half_r;
   logic [7:0] scnt_r; // Remaining sync cycles.
   logic sync_r;
   logic sync_irq_r;
   logic tripped_r; // Latched shutdown.
   logic [7:0] chop_cnt_r;
   logic chop_r;
   logic [5:0] out_r; // Order: a_high, a_low, b_high, b_low, c_high, c_low.
   logic wait_r;
   logic [31:0] readdata_r;
   logic [8:0] len_r; // Sync length seen, for checking only.
   // Synchronised inputs: index 0 is the trip pin, index 1 the analog source.
   logic [1:0] filt_r;
   localparam logic [1:0] IDLE = 2'b01;

   // Bus decode: an access completes in the cycle after it is seen.
   wire [3:0] ix = avs_address[5:2];
   wire wr_en = avs_write && !wait_r;
   wire rd_go = avs_read && wait_r;
   wire wr_sws = wr_en && (ix == `TPWM_IX_SWS);
   wire wr_clr = wr_en && (ix == `TPWM_IX_STAT) && avs_writedata[`TPWM_ST_SHUT];
   wire dbl = mode_control_reg[`TPWM_MODE_DBL];
   wire half2 = (half_r == tpwm_pkg::TPWM_SECOND);
   // Status: trip level, latched shutdown, period half.
   wire [31:0] stat_w = {28'h0000000, half2, 1'b0, tripped_r, filt_r[0]};
   wire [31:0] rd_mux =
      (ix == `TPWM_IX_TM) ? {16'h0000, half_period_count_reg} :
      (ix == `TPWM_IX_DT) ? {22'h000000, dead_time_reg} :
      (ix == `TPWM_IX_PD) ? {22'h000000, pulse_deletion_reg} :
      (ix == `TPWM_IX_DA) ? {16'h0000, duty_reg[0]} :
      (ix == `TPWM_IX_DB) ? {16'h0000, duty_reg[1]} :
      (ix == `TPWM_IX_DC) ? {16'h0000, duty_reg[2]} :
      (ix == `TPWM_IX_SEG) ? {23'h000000, output_segment_reg} :
      (ix == `TPWM_IX_GATE) ? {22'h000000, gate_chop_ctrl_reg} :
      (ix == `TPWM_IX_MODE) ? {16'h0000, mode_control_reg} :
      (ix == `TPWM_IX_SYNCW) ? {24'h000000, sync_width_reg} :
      (ix == `TPWM_IX_STAT) ? stat_w : 32'h00000000;

   // Shutdown sources: trip low, analog high, or software write.
   wire shut_ev = !filt_r[0] || filt_r[1] || wr_sws;
   // A half ends on the last count; a tiny period ends every cycle.
   wire boundary = (tm_l <= 16'h0001) || (cnt_r >= tm_l - 16'h0001);
   // Update points: period start always, midpoint only in double mode.
   wire latch_ev = boundary && (half2 || dbl) && !tripped_r;
   // Trip acts on the output flops at once, clock or not.
   wire out_rst_n = rstn && trip_input_n;

   // Three-flop synchronisers; a change counts once stages two and three agree.
   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_sync
         logic [2:0] sr;
         // Shift chain and filter.
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               sr <= {3{IDLE[s]}};
               filt_r[s] <= IDLE[s];
            end else begin
               sr <= {sr[1:0], (s == 0) ? trip_input_n : analog_shutdown};
               if (sr[1] == sr[2]) begin
                  filt_r[s] <= sr[2];
               end
            end
         end
      end
   endgenerate

   // Avalon handshake: waitrequest drops for one cycle per access.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wait_r <= 1'b1;
         readdata_r <= 32'h00000000;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
         if (rd_go) begin
            readdata_r <= rd_mux;
         end
      end
   end

   // Software register writes.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         half_period_count_reg <= `TPWM_TM_RST;
         dead_time_reg <= 10'h000;
         pulse_deletion_reg <= 10'h000;
         duty_reg <= '{16'h0000, 16'h0000, 16'h0000};
         output_segment_reg <= `TPWM_SEG_RST;
         gate_chop_ctrl_reg <= 10'h000;
         mode_control_reg <= 16'h0000;
         sync_width_reg <= `TPWM_SYNCW_RST;
      end else if (wr_en) begin
         // Each register takes its own low bits of the word.
         unique case (ix)
            `TPWM_IX_TM: half_period_count_reg <= avs_writedata[15:0];
            `TPWM_IX_DT: dead_time_reg <= avs_writedata[9:0];
            `TPWM_IX_PD: pulse_deletion_reg <= avs_writedata[9:0];
            `TPWM_IX_DA: duty_reg[0] <= avs_writedata[15:0];
            `TPWM_IX_DB: duty_reg[1] <= avs_writedata[15:0];
            `TPWM_IX_DC: duty_reg[2] <= avs_writedata[15:0];
            `TPWM_IX_SEG: output_segment_reg <= avs_writedata[8:0];
            `TPWM_IX_GATE: gate_chop_ctrl_reg <= avs_writedata[9:0];
            `TPWM_IX_MODE: mode_control_reg <= avs_writedata[15:0];
            `TPWM_IX_SYNCW: sync_width_reg <= avs_writedata[7:0];
            default: ;
         endcase
      end
   end

   // Latched shutdown; a new shutdown beats a clear in the same cycle.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tripped_r <= 1'b0;
      end else if (shut_ev) begin
         tripped_r <= 1'b1;
      end else if (wr_clr) begin
         tripped_r <= 1'b0;
      end
   end

   // Parameter latch at each update point.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tm_l <= `TPWM_TM_RST;
         dt_l <= 10'h000;
         pd_l <= 10'h000;
         duty_l <= '{16'h0000, 16'h0000, 16'h0000};
         seg_l <= `TPWM_SEG_RST;
         syncw_l <= `TPWM_SYNCW_RST;
      end else if (latch_ev) begin
         tm_l <= half_period_count_reg;
         dt_l <= dead_time_reg;
         pd_l <= pulse_deletion_reg;
         duty_l <= duty_reg;
         seg_l <= output_segment_reg;
         syncw_l <= sync_width_reg;
      end
   end

   // Half-period counter; shutdown parks it so restart begins a period.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 16'hFFFF;
         half_r <= tpwm_pkg::TPWM_SECOND;
      end else if (tripped_r) begin
         cnt_r <= 16'hFFFF;
         half_r <= tpwm_pkg::TPWM_SECOND;
      end else if (boundary) begin
         cnt_r <= 16'h0000;
         half_r <= half2 ? tpwm_pkg::TPWM_FIRST : tpwm_pkg::TPWM_SECOND;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // Sync pulse of width plus one cycles, and its interrupt.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sync_r <= 1'b0;
         scnt_r <= 8'h00;
         sync_irq_r <= 1'b0;
      end else begin
         sync_irq_r <= latch_ev;
         if (tripped_r) begin
            sync_r <= 1'b0;
            scnt_r <= 8'h00;
         end else if (latch_ev) begin
            sync_r <= 1'b1;
            scnt_r <= sync_width_reg;
         end else if (scnt_r != 8'h00) begin
            scnt_r <= scnt_r - 8'h01;
         end else begin
            sync_r <= 1'b0;
         end
      end
   end

   // Chopping clock: toggles every gate field plus one cycles.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         chop_cnt_r <= 8'h00;
         chop_r <= 1'b0;
      end else if (chop_cnt_r >= gate_chop_ctrl_reg[7:0]) begin
         chop_cnt_r <= 8'h00;
         chop_r <= !chop_r;
      end else begin
         chop_cnt_r <= chop_cnt_r + 8'h01;
      end
   end

   // Per-phase waveform, dead time, crossover, enables and chopping.
   logic [5:0] out_nxt;
   logic [2:0] hi_t;
   logic [2:0] lo_t;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ph
         logic [10:0] dc_r; // Cycles since the raw edge.
         logic raw_r;
         wire [15:0] off_w = tm_l - duty_l[g];
         wire del_lo = duty_l[g] < {6'h00, pd_l};
         wire full_on = (duty_l[g] >= tm_l) || (off_w < {6'h00, pd_l});
         // On-time is centred: late in the first half, early in the second.
         wire raw = del_lo ? 1'b0 : full_on ? 1'b1 :
            (half2 ? (cnt_r < duty_l[g]) : (cnt_r >= off_w));
         wire dt_ok = dc_r >= {dt_l, 1'b0};
         wire xo = seg_l[`TPWM_SEG_XO + g];
         wire hi_x = xo ? lo_t[g] : hi_t[g];
         wire lo_x = xo ? hi_t[g] : lo_t[g];
         wire hi_c = hi_x && (!gate_chop_ctrl_reg[`TPWM_GATE_HI_EN] || chop_r);
         wire lo_c = lo_x && (!gate_chop_ctrl_reg[`TPWM_GATE_LO_EN] || chop_r);
         assign hi_t[g] = raw_r && dt_ok;
         assign lo_t[g] = !raw_r && dt_ok;
         assign out_nxt[2 * g] = hi_c && seg_l[2 * g] && !tripped_r;
         assign out_nxt[2 * g + 1] = lo_c && seg_l[2 * g + 1] && !tripped_r;
         // Dead-time counter restarts on every raw edge and saturates.
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               raw_r <= 1'b0;
               dc_r <= 11'h000;
            end else begin
               raw_r <= raw;
               if (raw != raw_r) begin
                  dc_r <= 11'h000;
               end else if (dc_r != 11'h7FF) begin
                  dc_r <= dc_r + 11'h001;
               end
            end
         end
      end
   endgenerate

   // Output flops, cleared at once by the trip pin.
   always_ff @(posedge ref_clk or negedge out_rst_n) begin
      if (!out_rst_n) begin
         out_r <= 6'h00;
      end else begin
         out_r <= out_nxt;
      end
   end

   // Sync length seen, restarted at each update point.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         len_r <= 9'h000;
      end else if (latch_ev) begin
         len_r <= 9'h000;
      end else if (sync_r) begin
         len_r <= len_r + 9'h001;
      end
   end

   // Ports.
   assign avs_readdata = readdata_r;
   assign avs_waitrequest = wait_r;
   assign phase_a_high = out_r[0];
   assign phase_a_low = out_r[1];
   assign phase_b_high = out_r[2];
   assign phase_b_low = out_r[3];
   assign phase_c_high = out_r[4];
   assign phase_c_low = out_r[5];
   assign period_sync_pulse = sync_r;
   assign sync_irq = sync_irq_r;
   assign shutdown_irq = tripped_r;

   // Checks.
   trip_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !trip_input_n |-> out_r == 6'h00) else $error("output on during trip");
   sync_width_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      $fell(sync_r) && !$past(tripped_r) |-> len_r == {1'b0, syncw_l} + 9'h001)
      else $error("sync width wrong");
   single_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(sync_r) && !$past(dbl) |-> !half2) else $error("single mode midpoint sync");
   half_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      boundary && !tripped_r |=> half_r != $past(half_r)) else $error("half not flipped");
   duty_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      boundary && !half2 && !dbl |=> $stable(duty_l[0])) else $error("midpoint update");
   shut_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      tripped_r && !wr_clr |=> tripped_r) else $error("shutdown released");
   sw_shut_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_sws |=> tripped_r ##1 out_r == 6'h00) else $error("software shutdown lost");
   seg_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !seg_l[0] |=> !out_r[0]) else $error("disabled output on");
   dead_pair_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !(out_r[0] && out_r[1]) && !(out_r[2] && out_r[3]) && !(out_r[4] && out_r[5]))
      else $error("pair overlap");
   bus_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !wait_r |=> wait_r) else $error("waitrequest low twice");
endmodule : tpwm_top

// ===== rtl/tpwm_consts.svh
// Register offsets, reset values and field positions of the three-phase modulator.
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH
// Register word indexes; the byte address is four times the index.
`define TPWM_IX_TM 4'h0
`define TPWM_IX_DT 4'h1
`define TPWM_IX_PD 4'h2
`define TPWM_IX_DA 4'h3
`define TPWM_IX_DB 4'h4
`define TPWM_IX_DC 4'h5
`define TPWM_IX_SEG 4'h6
`define TPWM_IX_GATE 4'h7
`define TPWM_IX_MODE 4'h8
`define TPWM_IX_SYNCW 4'h9
`define TPWM_IX_SWS 4'hA
`define TPWM_IX_STAT 4'hB
// Reset values of the software registers.
`define TPWM_TM_RST 16'h03E8
`define TPWM_SEG_RST 9'h03F
`define TPWM_SYNCW_RST 8'h27
// Field positions.
`define TPWM_MODE_DBL 6
`define TPWM_GATE_HI_EN 8
`define TPWM_GATE_LO_EN 9
`define TPWM_SEG_XO 6
`define TPWM_ST_TRIP 0
`define TPWM_ST_SHUT 1
`define TPWM_ST_HALF 3
`endif

// ===== rtl/tpwm_pkg.sv
// Types shared by the three-phase modulator.
package tpwm_pkg;
   // Which half of the switching period is running.
   typedef enum logic {TPWM_FIRST, TPWM_SECOND} tpwm_half_t;
   // One 16-bit timing word.
   typedef logic [15:0] tpwm_word_t;
endpackage : tpwm_pkg

// ===== dv/tpwm_gate_drv.sv
// Behavioural gate-driver stage of the inverter, with its fault comparator on the trip line.
`timescale 1ns/1ns
module tpwm_gate_drv (
   // Clock used to sample the gate levels.
   input wire logic ref_clk,
   // Fault request from the bench; high pulls the trip line low.
   input wire logic fault_req,
   // Gate levels: bit 2k is the high side and bit 2k+1 the low side of leg k.
   input wire logic [5:0] gate_lvl,
   // Trip line back to the modulator.
   output logic trip_input_n,
   // Cycles in which both switches of one leg were on.
   output logic [15:0] shoot_cnt
);
   // Both switches of one leg on together would short the dc link.
   wire logic both_on;
   // The fault output drives the trip line low on a request and high otherwise.
   assign trip_input_n = fault_req ? 1'b0 : 1'b1;
   // Any leg with both gates on counts as a shoot-through cycle.
   assign both_on = (gate_lvl[0] & gate_lvl[1]) | (gate_lvl[2] & gate_lvl[3])
      | (gate_lvl[4] & gate_lvl[5]);
   // The counter starts clear so one bad cycle is never missed.
   initial shoot_cnt = 16'h0000;
   // Samples the legs once a cycle, where the gate levels are settled.
   always @(posedge ref_clk) begin
      if (both_on === 1'b1) begin
         shoot_cnt <= shoot_cnt + 16'h0001;
      end
   end
endmodule : tpwm_gate_drv

// ===== dv/tpwm_tb_top.sv
// Self-checking bench for the three-phase modulator.
`timescale 1ns/1ns
`include "tpwm_consts.svh"
// Compares a value with its expectation and counts the outcome.
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %0t %s", $time, m); end end
module tpwm_tb_top;
   // Clock, reset and bus master signals.
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] rdata;
   logic wq;
   // Shutdown sources and the fault request to the driver model.
   logic ana = 1'b0;
   logic fault = 1'b0;
   wire trip_n;
   // Gate outputs in segment bit order, sync and interrupts.
   wire [5:0] pw;
   wire sync;
   wire s_irq;
   wire d_irq;
   wire [15:0] shoot;
   // Counters and scratch values.
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   int hc[6];
   int t0;
   int t1;
   int w;
   logic [31:0] q;
   logic v;
   // Design under test.
   tpwm_top tpwm_top_i (.ref_clk(ref_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wq),
      .trip_input_n(trip_n), .analog_shutdown(ana), .phase_a_high(pw[0]), .phase_a_low(pw[1]),
      .phase_b_high(pw[2]), .phase_b_low(pw[3]), .phase_c_high(pw[4]), .phase_c_low(pw[5]),
      .period_sync_pulse(sync), .sync_irq(s_irq), .shutdown_irq(d_irq));
   // Gate driver model on the far side.
   tpwm_gate_drv tpwm_gate_drv_i (.ref_clk(ref_clk), .fault_req(fault), .gate_lvl(pw),
      .trip_input_n(trip_n), .shoot_cnt(shoot));
   // Free-running 100 MHz clock.
   always #5 ref_clk = ~ref_clk;
   // Counts clock cycles and cuts a hung run short.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         results;
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   // Holds the request until waitrequest is seen low at a rising edge, counting wait edges.
   task automatic ack_wait;
      int n;
      n = 0;
      @(posedge ref_clk);
      while (wq !== 1'b0) begin
         n++;
         @(posedge ref_clk);
      end
      `CHK(n, 1, "one wait state per access")
   endtask : ack_wait
   // One bus write to a register index.
   task automatic bus_wr(input logic [3:0] ix, input logic [31:0] d);
      @(posedge ref_clk);
      adr <= {ix, 2'h0};
      wd <= d;
      wr <= 1'b1;
      ack_wait;
      wr <= 1'b0;
   endtask : bus_wr
   // One bus read from a register index.
   task automatic bus_rd(input logic [3:0] ix);
      @(posedge ref_clk);
      adr <= {ix, 2'h0};
      rd <= 1'b1;
      ack_wait;
      q = rdata;
      rd <= 1'b0;
   endtask : bus_rd
   // Waits for a sync rising edge and records its cycle.
   task automatic sync_rise(output int t);
      do @(negedge ref_clk); while (sync !== 1'b0);
      do @(negedge ref_clk); while (sync !== 1'b1);
      t = cyc;
      `CHK(s_irq, 1'b1, "sync interrupt missing")
   endtask : sync_rise
   // Measures sync width in w and the spacing of two rises in t1.
   task automatic sync_meas;
      sync_rise(t0);
      sync_rise(t0);
      w = 0;
      while (sync === 1'b1 && w < 300) begin
         w++;
         @(negedge ref_clk);
      end
      sync_rise(t1);
      t1 = t1 - t0;
   endtask : sync_meas
   // Counts the high cycles of each output over one steady period.
   task automatic window(input int e[6], input string m);
      sync_rise(t0);
      sync_rise(t0);
      repeat (8) @(negedge ref_clk);
      hc = '{default: 0};
      repeat (40) begin
         @(negedge ref_clk);
         for (int i = 0; i < 6; i++) hc[i] += pw[i];
      end
      for (int i = 0; i < 6; i++) `CHK(hc[i], e[i], m)
   endtask : window
   // Reset values and an unmapped index.
   task automatic t_reset;
      bus_rd(`TPWM_IX_TM);
      `CHK(q[15:0], 16'h03E8, "period reset")
      bus_rd(`TPWM_IX_SYNCW);
      `CHK(q[7:0], 8'h27, "sync width reset")
      bus_rd(`TPWM_IX_MODE);
      `CHK(q[6], 1'b0, "mode reset")
      bus_rd(`TPWM_IX_SEG);
      `CHK(q[8:0], 9'h03F, "segment reset")
      bus_wr(4'hC, 32'hFFFFFFFF);
      bus_rd(4'hC);
      `CHK(q, 32'h00000000, "unmapped read")
   endtask : t_reset
   // Period length and sync width at two widths.
   task automatic t_timing;
      bus_wr(`TPWM_IX_TM, 32'h14);
      bus_wr(`TPWM_IX_DT, 32'h0);
      bus_wr(`TPWM_IX_PD, 32'h0);
      bus_wr(`TPWM_IX_SYNCW, 32'h3);
      sync_meas;
      `CHK(w, 4, "sync width")
      `CHK(t1, 40, "period length")
      bus_wr(`TPWM_IX_SYNCW, 32'h0);
      sync_meas;
      `CHK(w, 1, "minimum sync width")
   endtask : t_timing
   // Double update: midpoint sync and the half flag, then back to single.
   task automatic t_double;
      bus_wr(`TPWM_IX_MODE, 32'h40);
      bus_rd(`TPWM_IX_MODE);
      `CHK(q[6], 1'b1, "mode readback")
      sync_meas;
      `CHK(t1, 20, "double sync spacing")
      sync_rise(t0);
      bus_rd(`TPWM_IX_STAT);
      v = q[3];
      sync_rise(t0);
      bus_rd(`TPWM_IX_STAT);
      `CHK(q[3], ~v, "half flag toggles")
      bus_wr(`TPWM_IX_MODE, 32'h0);
      sync_meas;
      `CHK(t1, 40, "single sync spacing")
   endtask : t_double
   // Duty, dead time, deletion, enables, crossover and chopping.
   task automatic t_outputs;
      bus_wr(`TPWM_IX_DA, 32'h14);
      bus_wr(`TPWM_IX_DB, 32'h0);
      bus_wr(`TPWM_IX_DC, 32'hA);
      window('{40, 0, 0, 40, 20, 20}, "duty");
      bus_wr(`TPWM_IX_DT, 32'h2);
      window('{40, 0, 0, 40, 16, 16}, "dead time");
      bus_wr(`TPWM_IX_DT, 32'h0);
      bus_wr(`TPWM_IX_PD, 32'h5);
      bus_wr(`TPWM_IX_DC, 32'h3);
      window('{40, 0, 0, 40, 0, 40}, "pulse deletion");
      bus_wr(`TPWM_IX_PD, 32'h0);
      bus_wr(`TPWM_IX_DC, 32'hA);
      bus_wr(`TPWM_IX_SEG, 32'h08E);
      window('{0, 0, 40, 0, 0, 0}, "enable and crossover");
      bus_wr(`TPWM_IX_SEG, 32'h1FF);
      window('{0, 40, 40, 0, 20, 20}, "crossover all");
      bus_wr(`TPWM_IX_SEG, 32'h03F);
      bus_wr(`TPWM_IX_GATE, 32'h101);
      window('{20, 0, 0, 40, 10, 20}, "high chop");
      bus_wr(`TPWM_IX_GATE, 32'h204);
      window('{40, 0, 0, 20, 20, 10}, "low chop");
      bus_wr(`TPWM_IX_GATE, 32'h0);
      sync_rise(t0);
      repeat (5) @(negedge ref_clk);
      bus_wr(`TPWM_IX_DA, 32'h0);
      repeat (20) @(negedge ref_clk);
      `CHK(pw[0], 1'b1, "duty taken mid-period")
      sync_rise(t0);
      repeat (6) @(negedge ref_clk);
      `CHK(pw[0], 1'b0, "duty taken at start")
      bus_wr(`TPWM_IX_DA, 32'h14);
   endtask : t_outputs
   // Clears a latched shutdown and checks the modulator restarts.
   task automatic restart;
      bus_wr(`TPWM_IX_STAT, 32'h2);
      sync_rise(t0);
      `CHK(d_irq, 1'b0, "shutdown irq cleared")
      repeat (6) @(negedge ref_clk);
      `CHK(pw[3], 1'b1, "outputs back")
   endtask : restart
   // Software, trip and analog shutdown.
   task automatic t_shut;
      bus_wr(`TPWM_IX_SWS, 32'h1);
      repeat (4) @(negedge ref_clk);
      `CHK(pw, 6'h00, "software shutdown")
      `CHK(d_irq, 1'b1, "shutdown irq")
      w = 0;
      repeat (100) @(negedge ref_clk) w += sync;
      `CHK(w, 0, "no sync while shut")
      bus_rd(`TPWM_IX_STAT);
      `CHK(q[1], 1'b1, "shutdown latched")
      restart;
      @(posedge ref_clk);
      fault <= 1'b1;
      #1;
      `CHK(pw, 6'h00, "trip forces off")
      repeat (6) @(negedge ref_clk);
      bus_rd(`TPWM_IX_STAT);
      `CHK(q[1:0], 2'b10, "trip status")
      @(posedge ref_clk);
      fault <= 1'b0;
      repeat (6) @(negedge ref_clk);
      restart;
      bus_rd(`TPWM_IX_STAT);
      `CHK(q[1:0], 2'b01, "trip released")
      @(posedge ref_clk);
      ana <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ana <= 1'b0;
      repeat (4) @(negedge ref_clk);
      `CHK(d_irq, 1'b1, "analog shutdown")
      `CHK(pw, 6'h00, "analog forces off")
      restart;
   endtask : t_shut
   // Main sequence: reset for eight cycles, then the scenarios.
   initial begin
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset;
      t_timing;
      t_double;
      t_outputs;
      t_shut;
      `CHK(shoot, 16'h0000, "both gates of a leg on")
      results;
   end
endmodule : tpwm_tb_top
